//--- design/eipl_top.sv
/*
  External interrupt pin latch with an APB register slave.
  Holds the active-low pin synchroniser, the request latch, mask,
  pending flag, pull-up control, break-state flag protection and a
  sticky event status with its own interrupt output.
  Assumes: APB master on pclk, pin driven by an outside device,
  processor supplies vector fetch and break state as pclk-synchronous
  levels.
*/
// The APB slave port and the register offsets were decided locally.
module eipl_top (
  // clock and reset
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  // apb slave
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [eipl_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [eipl_pkg::DATA_W-1:0]  pwdata,
  output logic      [eipl_pkg::DATA_W-1:0]  prdata,
  output logic                              pready,
  output logic                              pslverr,
  // external pin
  input  wire logic                         ext_int_pin_n,
  output logic                              pin_pullup_en,
  // processor side
  input  wire logic                         vector_fetch,
  input  wire logic                         break_state,
  output logic                              cpu_int_req,
  output logic      [15:0]                  int_vector,
  output logic                              pin_level,
  // event interrupt
  output logic                              irq
);

  //////////////////////////////////////////////////////////////////////
  // address decode helper, used by every register access
  function automatic logic reg_hit(
    input logic [eipl_pkg::ADDR_W-1:0] a,
    input logic [7:0]                  off
  );
    return a == off;
  endfunction : reg_hit

  function automatic logic reg_mapped(
    input logic [eipl_pkg::ADDR_W-1:0] a
  );
    return reg_hit(a, eipl_pkg::OFF_STATUS_CONTROL)
         | reg_hit(a, eipl_pkg::OFF_SECOND_CONFIG)
         | reg_hit(a, eipl_pkg::OFF_BREAK_FLAG_CTL)
         | reg_hit(a, eipl_pkg::OFF_EVENT_STATUS)
         | reg_hit(a, eipl_pkg::OFF_EVENT_MASK)
         | reg_hit(a, eipl_pkg::OFF_PIN_LEVEL);
  endfunction : reg_mapped

  //////////////////////////////////////////////////////////////////////
  // declarations
  logic                          pin_s1_r;
  logic                          pin_s2_r;
  logic                          pin_s3_r;
  logic                          pin_fall;
  logic                          pin_low;
  logic                          mode_r;
  logic                          mask_r;
  logic                          pud_r;
  logic                          break_clear_flag_enable_r;
  eipl_pkg::eipl_state_t         state_r;
  eipl_pkg::eipl_state_t         state_nxt;
  logic                          pending;
  eipl_pkg::eipl_evt_t           status_r;
  eipl_pkg::eipl_evt_t           evt_mask_r;
  eipl_pkg::eipl_evt_t           evt_set;
  eipl_pkg::eipl_evt_t           evt_clr;
  logic [eipl_pkg::DATA_W-1:0]   rd_val;
  logic                          wr_acc;
  logic                          rd_setup;
  logic                          rd_acc;
  logic                          wr_ctrl;
  logic                          sw_ack_req;
  logic                          sw_ack;
  logic                          ack;

  //////////////////////////////////////////////////////////////////////
  // bus phase decode; zero wait states, so pready stays high
  assign wr_acc   = psel & penable & pwrite;
  assign rd_acc   = psel & penable & ~pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign wr_ctrl  = wr_acc & reg_hit(paddr, eipl_pkg::OFF_STATUS_CONTROL);
  assign pready   = 1'h1;
  assign pslverr  = psel & penable & ~reg_mapped(paddr);

  //////////////////////////////////////////////////////////////////////
  // pin synchroniser; first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_r <= eipl_pkg::PIN_IDLE;
      pin_s2_r <= eipl_pkg::PIN_IDLE;
      pin_s3_r <= eipl_pkg::PIN_IDLE;
    end else begin
      pin_s1_r <= ext_int_pin_n;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end

  // edge and level seen after the synchroniser only
  assign pin_fall  = pin_s3_r & ~pin_s2_r;
  assign pin_low   = ~pin_s2_r;
  assign pin_level = pin_s2_r;

  //////////////////////////////////////////////////////////////////////
  // acknowledge sources; software one is blocked in break unless enabled
  assign sw_ack_req = wr_ctrl & pwdata[eipl_pkg::CTL_ACK_B];
  assign sw_ack     = sw_ack_req & (~break_state | break_clear_flag_enable_r);
  assign ack        = vector_fetch | sw_ack;

  //////////////////////////////////////////////////////////////////////
  // request latch next state; a new edge beats a same-cycle acknowledge
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      eipl_pkg::ST_IDLE: begin
        if (pin_fall || (mode_r && pin_low)) begin
          state_nxt = eipl_pkg::ST_PEND;
        end
      end
      eipl_pkg::ST_PEND: begin
        if (ack && !pin_fall) begin
          // level mode waits for the pin to rise before letting go
          state_nxt = (mode_r && pin_low) ? eipl_pkg::ST_HELD
                                          : eipl_pkg::ST_IDLE;
        end
      end
      eipl_pkg::ST_HELD: begin
        if (!mode_r || !pin_low) begin
          state_nxt = eipl_pkg::ST_IDLE;
        end
      end
      default: state_nxt = eipl_pkg::ST_IDLE;
    endcase
  end

  // latch state; reset drops it whatever the pin does
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= eipl_pkg::ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign pending = (state_r != eipl_pkg::ST_IDLE);

  //////////////////////////////////////////////////////////////////////
  // processor request and vector
  assign cpu_int_req = pending & ~mask_r;
  assign int_vector  = cpu_int_req ? eipl_pkg::INT_VECTOR_ADDR
                                   : 16'h0000;

  //////////////////////////////////////////////////////////////////////
  // control bits in the status and control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= eipl_pkg::MODE_RST;
      mask_r <= eipl_pkg::MASK_RST;
    end else if (wr_ctrl) begin
      mode_r <= pwdata[eipl_pkg::CTL_MODE_B];
      mask_r <= pwdata[eipl_pkg::CTL_MASK_B];
    end
  end

  // pull-up disable; pull-up connected unless disabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pud_r <= eipl_pkg::PUD_RST;
    end else if (wr_acc
                 && reg_hit(paddr, eipl_pkg::OFF_SECOND_CONFIG)) begin
      pud_r <= pwdata[eipl_pkg::CFG2_PUD_B];
    end
  end

  assign pin_pullup_en = ~pud_r;

  // break clear-flag enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      break_clear_flag_enable_r <= eipl_pkg::BREAK_CLEAR_FLAG_ENABLE_RST;
    end else if (wr_acc
                 && reg_hit(paddr, eipl_pkg::OFF_BREAK_FLAG_CTL)) begin
      break_clear_flag_enable_r <= pwdata[eipl_pkg::BFC_BREAK_CLEAR_FLAG_ENABLE_B];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // sticky events; read clears only what was returned, set wins
  assign evt_set.req_latched = (state_r == eipl_pkg::ST_IDLE)
                             & (state_nxt == eipl_pkg::ST_PEND);
  assign evt_set.ack_taken   = ack & pending;
  // break without clear enable keeps every status bit for the debugger
  assign evt_clr = (rd_acc && reg_hit(paddr, eipl_pkg::OFF_EVENT_STATUS)
                    && (!break_state || break_clear_flag_enable_r))
                 ? eipl_pkg::eipl_evt_t'(prdata[eipl_pkg::EVT_W-1:0])
                 : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_r <= '0;
    end else begin
      status_r <= (status_r & ~evt_clr) | evt_set;
    end
  end

  // event mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_mask_r <= '0;
    end else if (wr_acc
                 && reg_hit(paddr, eipl_pkg::OFF_EVENT_MASK)) begin
      evt_mask_r <= eipl_pkg::eipl_evt_t'(pwdata[eipl_pkg::EVT_W-1:0]);
    end
  end

  assign irq = |(status_r & evt_mask_r);

  //////////////////////////////////////////////////////////////////////
  // read mux; ack bit is write-only and reads zero
  always_comb begin
    rd_val = '0;
    if (reg_hit(paddr, eipl_pkg::OFF_STATUS_CONTROL)) begin
      rd_val[eipl_pkg::CTL_MODE_B] = mode_r;
      rd_val[eipl_pkg::CTL_MASK_B] = mask_r;
      rd_val[eipl_pkg::CTL_PEND_B] = pending;
    end
    if (reg_hit(paddr, eipl_pkg::OFF_SECOND_CONFIG)) begin
      rd_val[eipl_pkg::CFG2_PUD_B] = pud_r;
    end
    if (reg_hit(paddr, eipl_pkg::OFF_BREAK_FLAG_CTL)) begin
      rd_val[eipl_pkg::BFC_BREAK_CLEAR_FLAG_ENABLE_B] = break_clear_flag_enable_r;
    end
    if (reg_hit(paddr, eipl_pkg::OFF_EVENT_STATUS)) begin
      rd_val[eipl_pkg::EVT_W-1:0] = status_r;
    end
    if (reg_hit(paddr, eipl_pkg::OFF_EVENT_MASK)) begin
      rd_val[eipl_pkg::EVT_W-1:0] = evt_mask_r;
    end
    if (reg_hit(paddr, eipl_pkg::OFF_PIN_LEVEL)) begin
      rd_val[eipl_pkg::PIN_LEVEL_B] = pin_s2_r;
    end
  end

  // read data caught in setup so it stands through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (rd_setup) begin
      prdata <= rd_val;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_sync_two_stage: assert property (
    ($past(presetn, 2) && $past(presetn))
      |-> (pin_level == $past(ext_int_pin_n, 2)))
    else $error("pin level not two cycles behind pin");

  a_edge_latches: assert property (
    (state_r == eipl_pkg::ST_IDLE && pin_fall) |=> pending)
    else $error("falling edge did not latch request");

  a_level_latches: assert property (
    (state_r == eipl_pkg::ST_IDLE && mode_r && pin_low) |=> pending)
    else $error("low level did not latch in level mode");

  a_edge_ack_clear: assert property (
    (!mode_r && pending && ack && !pin_fall) |=> !pending)
    else $error("edge mode acknowledge did not clear");

  a_level_hold: assert property (
    (mode_r && pin_low && pending && !wr_ctrl) |=> pending)
    else $error("level request dropped while pin low");

  a_held_release: assert property (
    (state_r == eipl_pkg::ST_HELD && !pin_low && !pin_fall)
      |=> !pending ##1 (pending == $past(pin_fall || pin_low && mode_r)))
    else $error("held request not released on pin high");

  a_break_protect: assert property (
    (break_state && !break_clear_flag_enable_r && sw_ack_req && !vector_fetch
      && state_r == eipl_pkg::ST_PEND) |=> pending)
    else $error("acknowledge cleared latch in protected break");

  a_break_clear: assert property (
    (break_state && break_clear_flag_enable_r && sw_ack_req && !mode_r && pending
      && !pin_fall) |=> !pending)
    else $error("enabled break acknowledge did not clear");

  a_req_vector: assert property (
    (pending && !mask_r)
      |-> (cpu_int_req && int_vector == eipl_pkg::INT_VECTOR_ADDR))
    else $error("unmasked request not presented with vector");

  a_event_sticky: assert property (
    evt_set.req_latched |=> status_r.req_latched)
    else $error("latch event lost from status");

  a_ack_clears: assert property (
    (ack && !pin_low) |=> !pending)
    else $error("acknowledge with pin high left request pending");

  a_fetch_clears: assert property (
    (vector_fetch && !mode_r && !pin_fall) |=> !pending)
    else $error("vector fetch did not clear edge request");

  a_fresh_edge: assert property (
    (state_r == eipl_pkg::ST_PEND && ack && pin_fall) |=> pending)
    else $error("new edge with acknowledge was lost");

  a_pending_read: assert property (
    (rd_setup && reg_hit(paddr, eipl_pkg::OFF_STATUS_CONTROL))
      |=> (prdata[eipl_pkg::CTL_PEND_B] == $past(pending)))
    else $error("pending flag not returned on read");

  a_pin_read: assert property (
    (rd_setup && reg_hit(paddr, eipl_pkg::OFF_PIN_LEVEL))
      |=> (prdata[eipl_pkg::PIN_LEVEL_B] == $past(pin_level)))
    else $error("pin level not returned on read");

  a_pullup_ctl: assert property (
    (wr_acc && reg_hit(paddr, eipl_pkg::OFF_SECOND_CONFIG))
      |=> (pin_pullup_en == !$past(pwdata[eipl_pkg::CFG2_PUD_B])))
    else $error("pull-up does not follow disable bit");

  a_break_clear_flag_enable_write: assert property (
    (wr_acc && reg_hit(paddr, eipl_pkg::OFF_BREAK_FLAG_CTL))
      |=> (break_clear_flag_enable_r == $past(pwdata[eipl_pkg::BFC_BREAK_CLEAR_FLAG_ENABLE_B])))
    else $error("break clear enable write not kept");

  a_status_protect: assert property (
    (break_state && !break_clear_flag_enable_r && rd_acc
      && reg_hit(paddr, eipl_pkg::OFF_EVENT_STATUS))
      |=> (($past(status_r) & ~status_r) == '0))
    else $error("status bit cleared in protected break");

  a_mask_gates: assert property (
    mask_r |-> !cpu_int_req)
    else $error("masked request reached processor");

endmodule : eipl_top

//--- dv/eipl_pin_drv.sv
/*
  Model of the outside device on the active-low interrupt pin.
  Assumes the bench commands when the device pulls the pin low.
*/
module eipl_pin_drv (
  // clock
  input  wire logic pclk,
  // command and pad state
  input  wire logic hold_low,
  input  wire logic pullup_en,
  // pin
  output logic      pin_n
);
  timeunit 1ns;
  timeprecision 1ps;

  logic float_r;

  // an undriven pad with no pull-up must not settle to a friendly value
  always_ff @(posedge pclk) begin
    float_r <= (float_r !== 1'b1);
  end

  // released pin rests high only through the pull-up
  assign pin_n = hold_low ? 1'b0 : (pullup_en ? 1'b1 : float_r);

endmodule : eipl_pin_drv

//--- dv/eipl_tb_top.sv
/*
  Self-checking bench for the interrupt pin latch.
  Assumes the design answers APB with pready and the pin model above.
*/
module eipl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        vector_fetch, break_state, hold_low, pin_n, pup;
  logic        cpu_int_req, pin_level, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] int_vector;
  logic [32:0] exp_q[$];
  int          fail_count, check_count, seed;

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  eipl_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_int_pin_n(pin_n), .pin_pullup_en(pup),
    .vector_fetch(vector_fetch), .break_state(break_state),
    .cpu_int_req(cpu_int_req), .int_vector(int_vector),
    .pin_level(pin_level), .irq(irq));

  eipl_pin_drv pin_u (.pclk(pclk), .hold_low(hold_low), .pullup_en(pup),
    .pin_n(pin_n));

  //////////////////////////////////////////////////////////////////////
  // comparison and verdict
  task automatic chk(input string nm, input logic [32:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic complete_run;
    if (fail_count == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick

  //////////////////////////////////////////////////////////////////////
  // apb master; two idle edges after so flop-driven outputs settle
  task automatic apb(input logic w, input logic [7:0] a, d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {$random(seed) & 32'hFFFFFF00} | {24'h0, d};
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20) begin
      fail_count++;
      complete_run();
    end else begin
      psel    <= 1'b0;
      penable <= 1'b0;
      repeat (2) @(posedge pclk);
    end
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 8'h00);
  endtask : rd

  task automatic wr(input logic [7:0] a, d);
    apb(1'b1, a, d);
  endtask : wr

  // read monitor: oldest note against {pslverr, prdata} at access edge
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      if (exp_q.size() == 0) begin
        chk("read queue", 33'h1, 33'h0);
      end else begin
        chk("read data", {pslverr, prdata}, exp_q.pop_front());
      end
    end
  end

  // hang guard
  initial begin
    tick(20000);
    fail_count++;
    complete_run();
  end

  //////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    seed = 91473;
    fail_count = 0;
    check_count = 0;
    {presetn, psel, penable, pwrite, vector_fetch} = 5'h00;
    {break_state, hold_low, paddr, pwdata} = 42'h0;
    tick(2);
    presetn <= 1'b1;
    rd(8'h00, 33'h0);
    rd(8'h04, 33'h0);
    rd(8'h08, 33'h0);
    rd(8'h14, 33'h1);
    chk("pullup", pup, 33'h1);
    rd(8'h20, 33'h100000000);
    // edge mode: latch, mask, ack with pin still low
    hold_low <= 1'b1;
    tick(4);
    chk("req", {cpu_int_req, int_vector}, 33'h1FFFA);
    wr(8'h00, 8'h02);
    chk("masked", cpu_int_req, 33'h0);
    rd(8'h00, 33'h0A);
    wr(8'h00, 8'h04);
    rd(8'h00, 33'h0);
    hold_low <= 1'b0;
    tick(4);
    hold_low <= 1'b1;
    tick(4);
    rd(8'h00, 33'h08);
    vector_fetch <= 1'b1;
    tick(1);
    vector_fetch <= 1'b0;
    tick(2);
    rd(8'h00, 33'h0);
    // level mode, masked while serviced
    wr(8'h00, 8'h03);
    rd(8'h00, 33'h0B);
    wr(8'h00, 8'h07);
    rd(8'h00, 33'h0B);
    hold_low <= 1'b0;
    tick(4);
    rd(8'h00, 33'h03);
    hold_low <= 1'b1;
    tick(4);
    hold_low <= 1'b0;
    tick(4);
    rd(8'h00, 33'h0B);
    wr(8'h00, 8'h07);
    rd(8'h00, 33'h03);
    // break protection
    wr(8'h00, 8'h00);
    hold_low <= 1'b1;
    tick(4);
    break_state <= 1'b1;
    wr(8'h00, 8'h04);
    rd(8'h00, 33'h08);
    rd(8'h0C, 33'h3);
    wr(8'h08, 8'h80);
    rd(8'h08, 33'h80);
    wr(8'h00, 8'h04);
    break_state <= 1'b0;
    tick(2);
    rd(8'h00, 33'h0);
    // pin level and pull-up control
    rd(8'h14, 33'h0);
    chk("level", pin_level, 33'h0);
    wr(8'h04, 8'h01);
    chk("pullup", pup, 33'h0);
    rd(8'h04, 33'h1);
    wr(8'h04, 8'h00);
    // event interrupt: sticky status, mask, read clear
    rd(8'h0C, 33'h3);
    rd(8'h0C, 33'h0);
    wr(8'h10, 8'h01);
    rd(8'h10, 33'h1);
    hold_low <= 1'b0;
    tick(4);
    hold_low <= 1'b1;
    tick(4);
    chk("irq", irq, 33'h1);
    rd(8'h0C, 33'h1);
    chk("irq", irq, 33'h0);
    wr(8'h00, 8'h04);
    chk("irq", irq, 33'h0);
    // reset in mid-run with a level request and the pin low
    wr(8'h00, 8'h01);
    presetn <= 1'b0;
    tick(2);
    chk("rst req", cpu_int_req, 33'h0);
    presetn <= 1'b1;
    tick(1);
    chk("rst req", cpu_int_req, 33'h0);
    tick(4);
    rd(8'h00, 33'h08);
    complete_run();
  end

endmodule : eipl_tb_top

//--- pkg/eipl_pkg.sv
/*
  Shared constants and types for the external interrupt pin latch:
  register offsets, bit positions, reset values, vector address,
  latch states and the event record.
  Assumes a 32-bit APB with byte addresses and one word per register.
*/
package eipl_pkg;

  //////////////////////////////////////////////////////////////////////
  // bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  //////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] OFF_STATUS_CONTROL = 8'h00;
  localparam logic [7:0] OFF_SECOND_CONFIG  = 8'h04;
  localparam logic [7:0] OFF_BREAK_FLAG_CTL = 8'h08;
  localparam logic [7:0] OFF_EVENT_STATUS   = 8'h0C;
  localparam logic [7:0] OFF_EVENT_MASK     = 8'h10;
  localparam logic [7:0] OFF_PIN_LEVEL      = 8'h14;

  //////////////////////////////////////////////////////////////////////
  // field positions
  localparam int CTL_MODE_B    = 0;  // sensitivity select
  localparam int CTL_MASK_B    = 1;  // ext_int_mask
  localparam int CTL_ACK_B     = 2;  // write-one acknowledge
  localparam int CTL_PEND_B    = 3;  // ext_int_pending_flag
  localparam int CFG2_PUD_B    = 0;  // pin_pullup_disable
  localparam int BFC_BREAK_CLEAR_FLAG_ENABLE_B    = 7;  // break_clear_flag_enable
  localparam int PIN_LEVEL_B   = 0;

  //////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic MODE_RST    = 1'h0;
  localparam logic MASK_RST    = 1'h0;
  localparam logic PUD_RST     = 1'h0;
  localparam logic BREAK_CLEAR_FLAG_ENABLE_RST    = 1'h0;
  localparam logic PIN_IDLE    = 1'h1;  // pin rests high

  //////////////////////////////////////////////////////////////////////
  // vector location of this interrupt (high byte first)
  localparam logic [15:0] INT_VECTOR_ADDR = 16'hFFFA;

  //////////////////////////////////////////////////////////////////////
  // latch states, gray along idle -> pending -> held
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_PEND = 2'h1,
    ST_HELD = 2'h3
  } eipl_state_t;

  // sticky event record, also the layout of status and mask registers
  typedef struct packed {
    logic ack_taken;
    logic req_latched;
  } eipl_evt_t;

  localparam int EVT_W = $bits(eipl_evt_t);

endpackage : eipl_pkg
